// file: pcmsl_codec.sv
// Purpose: Codec model driving frames of 40 bit clocks
// Assumes: Bit clock 160 ns, still between frames
// Notes:   Samples data out late in each bit, as the output lags the rise
`timescale 1ns/1ps
`default_nettype none
module pcmsl_codec (
  // Link toward the device
  output logic      bclk,
  output logic      fs,
  output logic      din,
  input  wire logic dout
);
  // Idle link
  initial begin
    bclk = 1'b0;
    fs = 1'b0;
    din = 1'b0;
  end
  // One frame: pattern out MSB first, capture in
  task automatic frame(input logic [39:0] p, output logic [39:0] c);
    #3;
    for (int i = 0; i < 40; i++) begin
      fs = (i == 0);
      din = p[39 - i];
      #20 bclk = 1'b1;
      #80 bclk = 1'b0;
      #55 c[39 - i] = dout;
      #5;
    end
    fs = 1'b0;
    din = ~din; // Released line shows no stale value
  endtask : frame
endmodule : pcmsl_codec
`default_nettype wire

// file: pcmsl_pkg.sv
// Purpose: Shared constants and types for the PCM slot placement and DMA pacing block
// Assumes: 32-bit AXI4-Lite register bus, 64-word FIFOs in each direction
// Notes:   All offsets are byte addresses of aligned 32-bit words
`default_nettype none
package pcmsl_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RX_SLOT = 8'h00; // receive_slot_config
  localparam logic [7:0] OFS_TX_SLOT = 8'h04; // transmit_slot_config
  localparam logic [7:0] OFS_THR     = 8'h08; // dma_threshold_config
  localparam logic [7:0] OFS_CTRL    = 8'h0c; // Run and pair packing
  localparam logic [7:0] OFS_STAT    = 8'h10; // FIFO levels, read only
  localparam logic [7:0] OFS_FIFO    = 8'h14; // Write pushes TX, read pops RX
  // ----------------------------------------------------------------
  // Slot field positions (first slot in upper half)
  // ----------------------------------------------------------------
  localparam int SLOT_HALF   = 16;  // Second slot fields sit this much lower
  localparam int SLOT_MSB    = 31;  // Width extension bit
  localparam int SLOT_EN     = 30;  // Slot enable
  localparam int SLOT_POS_LO = 20;  // Ten-bit position field
  localparam int SLOT_WID_LO = 16;  // Four-bit width code
  localparam int POS_W       = 10;
  localparam logic [5:0] WID_BASE = 6'h08; // Code 0 means 8 bits
  localparam logic [5:0] WID_EXT  = 6'h10; // Weight of extension bit
  localparam logic [5:0] PACK_MAX = 6'h10; // Packed slots hold at most 16 bits
  // ----------------------------------------------------------------
  // Threshold fields and reset
  // ----------------------------------------------------------------
  localparam int THR_TXP_LO = 24;
  localparam int THR_RXP_LO = 16;
  localparam int THR_TXR_LO = 8;
  localparam int THR_RXR_LO = 0;
  localparam logic [31:0] THR_RESET = 32'h1030_3020;
  localparam logic [31:0] THR_MASK  = 32'h7f7f_7f7f;
  // ----------------------------------------------------------------
  // Control bits, FIFO shape, bus answers
  // ----------------------------------------------------------------
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_RXPK  = 1;
  localparam int CTRL_TXPK  = 2;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0007;
  localparam int STAT_TX_LO = 8;
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W      = 6;
  localparam int LVL_W      = 7;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // DMA pacing lines toward the DMA controller
  typedef struct packed {
    logic tx_dma_request_line;
    logic tx_panic;
    logic rx_dma_request_line;
    logic rx_panic;
  } pcmsl_dma_t;

  // One slot in flight: bits still to move and the shift register
  typedef struct packed {
    logic [5:0]  left;
    logic [31:0] sh;
  } pcmsl_chan_t;
endpackage : pcmsl_pkg
`default_nettype wire

// file: pcmsl_sva.sv
// Purpose: Port checks for pcmsl_top
// Assumes: One aclk domain
// Notes:   Bound to every pcmsl_top
`timescale 1ns/1ps
`default_nettype none
module pcmsl_sva (
  // Clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Bus handshakes
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [7:0]            s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  // Link and pacing
  input wire logic                  pcm_bit_clk,
  input wire logic                  pcm_data_out,
  input wire pcmsl_pkg::pcmsl_dma_t dma_request_line
);
  import pcmsl_pkg::*;
  // ------
  // Checks
  // ------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Lines idle at release, then TX asks since its FIFO is empty
  sequence s_wake;
    dma_request_line == 4'h0 ##1 dma_request_line == 4'hc;
  endsequence
  a_dma_wake: assert property ($rose(aresetn) |-> s_wake)
    else $error("pacing lines wrong after reset");
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read dropped");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
  // A held address or data word blocks the next one until the write is done
  a_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");
  a_w_block: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("second write data taken");
  a_bad_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h17 |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  // Output rises only a few cycles after a bit clock rise; stopping the
  // port may drop it to rest at any time, so only rises are timed
  a_dout_time: assert property ($rose(pcm_data_out) |->
    $past(pcm_bit_clk, 2) || $past(pcm_bit_clk, 3) || $past(pcm_bit_clk, 5))
    else $error("data out moved off the bit clock");
endmodule : pcmsl_sva
bind pcmsl_top pcmsl_sva u_pcmsl_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pcm_bit_clk, .pcm_data_out,
  .dma_request_line);
`default_nettype wire

// file: pcmsl_top.sv
// Purpose: Slot placement and DMA pacing for a PCM serial audio port
// Assumes: Bit clock, frame sync and data in come from the codec
// Notes:   Everything on the link happens at a rising bit clock edge, except stopping, which drops data out to rest at once
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pcmsl_top (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // PCM link pins
  input  wire logic                 pcm_bit_clk,
  input  wire logic                 pcm_frame_sync,
  input  wire logic                 pcm_data_in,
  output logic                      pcm_data_out,
  // DMA pacing
  output pcmsl_pkg::pcmsl_dma_t     dma_request_line
);
  import pcmsl_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]                        s1;       // Sync stage one
    logic [2:0]                        s2;       // Sync stage two
    logic                              clk_q;    // Last bit clock level
    logic                              fs_q;     // Frame sync at last rise
    logic [POS_W-1:0]                  cnt;      // Bit clock within frame
    pcmsl_chan_t [1:0]                 rx;       // Receive slots
    pcmsl_chan_t [1:0]                 tx;       // Transmit slots
    logic                              rx_half_v;
    logic [15:0]                       rx_half;  // Low half awaiting pair
    logic                              tx_half_v;
    logic [15:0]                       tx_half;  // High half for next slot
    logic                              dout;
    logic [FIFO_DEPTH-1:0][31:0]       rx_mem;
    logic [FIFO_DEPTH-1:0][31:0]       tx_mem;
    logic [PTR_W-1:0]                  rx_rd;
    logic [PTR_W-1:0]                  rx_wr;
    logic [PTR_W-1:0]                  tx_rd;
    logic [PTR_W-1:0]                  tx_wr;
    logic [LVL_W-1:0]                  rx_lvl;
    logic [LVL_W-1:0]                  tx_lvl;
    logic [31:0]                       rx_slot;
    logic [31:0]                       tx_slot;
    logic [31:0]                       thr;
    logic [31:0]                       ctrl;
    logic                              aw_v;     // Address held
    logic [7:0]                        aw_a;
    logic                              w_v;      // Data held
    logic [31:0]                       w_d;
    logic [3:0]                        w_s;
    logic                              awready;
    logic                              wready;
    logic                              bvalid;
    logic [1:0]                        bresp;
    logic                              arready;
    logic                              rvalid;
    logic [1:0]                        rresp;
    logic [31:0]                       rdata;
    pcmsl_dma_t                        dma;
  } pcmsl_state_t;

  pcmsl_state_t state_r;   // Registered state
  pcmsl_state_t state_nxt; // Next state

  // ----------------------------------------------------------------
  // Slot field decode
  // ----------------------------------------------------------------
  // Width in bit clocks; packed mode caps it at half a word
  function automatic logic [5:0] slot_width(input logic [31:0] cfg,
                                            input logic sec, input logic pk);
    logic [15:0] h;
    logic [5:0]  w;
    h = sec ? cfg[15:0] : cfg[31:16];
    w = (h[SLOT_MSB-SLOT_HALF] ? WID_EXT : 6'h00)
        + {2'h0, h[SLOT_WID_LO-SLOT_HALF +: 4]} + WID_BASE;
    if (pk && w > PACK_MAX) begin
      w = PACK_MAX;
    end
    return w;
  endfunction : slot_width

  function automatic logic [POS_W-1:0] slot_pos(input logic [31:0] cfg,
                                                input logic sec);
    logic [15:0] h;
    h = sec ? cfg[15:0] : cfg[31:16];
    return h[SLOT_POS_LO-SLOT_HALF +: POS_W];
  endfunction : slot_pos

  function automatic logic slot_en(input logic [31:0] cfg, input logic sec);
    return sec ? cfg[SLOT_EN-SLOT_HALF] : cfg[SLOT_EN];
  endfunction : slot_en

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Link, FIFO and bus share one process so FIFO updates stay single-driver
  always_comb begin
    logic             rise;
    logic             run;
    logic             rx_push;
    logic [31:0]      rx_word;
    logic             rx_pop;
    logic             tx_push;
    logic [31:0]      tx_word;
    logic             tx_pop;
    logic             tx_popped;
    logic [31:0]      head;
    logic [31:0]      data;
    logic [5:0]       w;
    logic             shown;
    logic             wr_go;
    state_nxt = state_r;
    rise      = 1'b0;
    run       = state_r.ctrl[CTRL_RUN];
    rx_push   = 1'b0;
    rx_word   = 32'h0000_0000;
    rx_pop    = 1'b0;
    tx_push   = 1'b0;
    tx_word   = 32'h0000_0000;
    tx_pop    = 1'b0;
    tx_popped = 1'b0;
    head      = state_r.tx_mem[state_r.tx_rd];
    data      = 32'h0000_0000;
    w         = 6'h00;
    shown     = 1'b0;
    wr_go     = 1'b0;

    // Pins pass two flops; edge found on the second stage only
    state_nxt.s1    = {pcm_data_in, pcm_frame_sync, pcm_bit_clk};
    state_nxt.s2    = state_r.s1;
    state_nxt.clk_q = state_r.s2[0];
    rise            = state_r.s2[0] && !state_r.clk_q;

    if (!run) begin
      // Idle: drop any slot in flight and any half-word pair
      state_nxt.cnt       = '0;
      state_nxt.rx        = '0;
      state_nxt.tx        = '0;
      state_nxt.rx_half_v = 1'b0;
      state_nxt.tx_half_v = 1'b0;
      state_nxt.dout      = 1'b0;
    end else if (rise) begin
      // Frame starts where sync is high after being low
      state_nxt.fs_q = state_r.s2[1];
      if (state_r.s2[1] && !state_r.fs_q) begin
        state_nxt.cnt = '0;
      end else begin
        state_nxt.cnt = state_r.cnt + 1'b1;
      end
      // Slots run on their own bit counts, so one that starts near
      // the frame end simply carries on past the next sync
      for (int c = 0; c < 2; c++) begin
        // Receive: shift in, push the word as its last bit lands
        if (state_r.rx[c].left != 6'h00) begin
          state_nxt.rx[c].sh   = {state_r.rx[c].sh[30:0], state_r.s2[2]};
          state_nxt.rx[c].left = state_r.rx[c].left - 1'b1;
          if (state_r.rx[c].left == 6'h01) begin
            // Completion order is frame order, not slot number
            if (state_r.ctrl[CTRL_RXPK]) begin
              if (!state_nxt.rx_half_v) begin
                state_nxt.rx_half   = state_nxt.rx[c].sh[15:0];
                state_nxt.rx_half_v = 1'b1;
              end else begin
                rx_push = 1'b1;
                rx_word = {state_nxt.rx[c].sh[15:0], state_nxt.rx_half};
                state_nxt.rx_half_v = 1'b0;
              end
            end else begin
              rx_push = 1'b1;
              rx_word = state_nxt.rx[c].sh;
            end
          end
        end else if (slot_en(state_r.rx_slot, c[0])
                     && state_nxt.cnt == slot_pos(state_r.rx_slot, c[0])) begin
          w = slot_width(state_r.rx_slot, c[0], state_r.ctrl[CTRL_RXPK]);
          state_nxt.rx[c].left = w - 1'b1;
          state_nxt.rx[c].sh   = {31'h0000_0000, state_r.s2[2]};
        end
        // Transmit: MSB first, word fetched at the slot's first clock
        if (state_r.tx[c].left != 6'h00) begin
          state_nxt.tx[c].sh   = {state_r.tx[c].sh[30:0], 1'b0};
          state_nxt.tx[c].left = state_r.tx[c].left - 1'b1;
          state_nxt.dout       = state_nxt.tx[c].sh[31];
          shown = 1'b1;
        end else if (slot_en(state_r.tx_slot, c[0])
                     && state_nxt.cnt == slot_pos(state_r.tx_slot, c[0])) begin
          w = slot_width(state_r.tx_slot, c[0], state_r.ctrl[CTRL_TXPK]);
          // Earliest slot in the frame takes the FIFO head
          if (state_r.ctrl[CTRL_TXPK] && state_nxt.tx_half_v) begin
            data = {16'h0000, state_nxt.tx_half};
            state_nxt.tx_half_v = 1'b0;
          end else begin
            // Underrun sends zeros; only one pop per rise
            if (state_r.tx_lvl != '0 && !tx_popped) begin
              data      = head;
              tx_pop    = 1'b1;
              tx_popped = 1'b1;
            end
            if (state_r.ctrl[CTRL_TXPK]) begin
              state_nxt.tx_half   = data[31:16];
              state_nxt.tx_half_v = 1'b1;
              data = {16'h0000, data[15:0]};
            end
          end
          state_nxt.tx[c].sh   = data << (6'd32 - w);
          state_nxt.tx[c].left = w - 1'b1;
          state_nxt.dout       = state_nxt.tx[c].sh[31];
          shown = 1'b1;
        end
      end
      // Outside any slot the line rests low
      if (!shown) begin
        state_nxt.dout = 1'b0;
      end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write: address and data taken in either order
    // ----------------------------------------------------------------
    if (s_axi_awvalid && state_r.awready) begin
      state_nxt.aw_v = 1'b1;
      state_nxt.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_r.wready) begin
      state_nxt.w_v = 1'b1;
      state_nxt.w_d = s_axi_wdata;
      state_nxt.w_s = s_axi_wstrb;
    end
    if (state_r.bvalid && s_axi_bready) begin
      state_nxt.bvalid = 1'b0;
    end
    wr_go = state_r.aw_v && state_r.w_v && !state_r.bvalid;
    if (wr_go) begin
      state_nxt.aw_v   = 1'b0;
      state_nxt.w_v    = 1'b0;
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp  = RESP_OKAY;
      // Slot and threshold writes are not guarded while running
      case ({state_r.aw_a[7:2], 2'b00})
        OFS_RX_SLOT: state_nxt.rx_slot = merge(state_r.rx_slot, state_r.w_d, state_r.w_s);
        OFS_TX_SLOT: state_nxt.tx_slot = merge(state_r.tx_slot, state_r.w_d, state_r.w_s);
        OFS_THR: begin
          // Reserved bits are not stored
          state_nxt.thr = merge(state_r.thr, state_r.w_d, state_r.w_s) & THR_MASK;
        end
        OFS_CTRL: begin
          state_nxt.ctrl = merge(state_r.ctrl, state_r.w_d, state_r.w_s) & CTRL_MASK;
        end
        OFS_STAT: begin
          // Read only, write ignored
        end
        OFS_FIFO: begin
          // Full FIFO drops the word
          if (state_r.tx_lvl != LVL_W'(FIFO_DEPTH)) begin
            tx_push = 1'b1;
            tx_word = state_r.w_d;
          end
        end
        default: state_nxt.bresp = RESP_SLVERR;
      endcase
    end
    // Ready only while the holding slot is free
    state_nxt.awready = !state_nxt.aw_v;
    state_nxt.wready  = !state_nxt.w_v;

    // ----------------------------------------------------------------
    // AXI4-Lite read: one cycle to data, popped FIFO reads
    // ----------------------------------------------------------------
    if (state_r.rvalid && s_axi_rready) begin
      state_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_r.arready) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp  = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        OFS_RX_SLOT: state_nxt.rdata = state_r.rx_slot;
        OFS_TX_SLOT: state_nxt.rdata = state_r.tx_slot;
        OFS_THR:     state_nxt.rdata = state_r.thr;
        OFS_CTRL:    state_nxt.rdata = state_r.ctrl;
        OFS_STAT: begin
          state_nxt.rdata = {17'h0_0000, state_r.tx_lvl, 1'b0, state_r.rx_lvl};
        end
        OFS_FIFO: begin
          // Empty FIFO reads zero and pops nothing
          state_nxt.rdata = 32'h0000_0000;
          if (state_r.rx_lvl != '0) begin
            state_nxt.rdata = state_r.rx_mem[state_r.rx_rd];
            rx_pop = 1'b1;
          end
        end
        default: begin
          state_nxt.rdata = 32'h0000_0000;
          state_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    state_nxt.arready = !state_nxt.rvalid;

    // ----------------------------------------------------------------
    // FIFO bookkeeping
    // ----------------------------------------------------------------
    // A full receive FIFO loses the new word (overrun)
    if (rx_push && state_r.rx_lvl == LVL_W'(FIFO_DEPTH)) begin
      rx_push = 1'b0;
    end
    if (rx_push) begin
      state_nxt.rx_mem[state_r.rx_wr] = rx_word;
      state_nxt.rx_wr = state_r.rx_wr + 1'b1;
    end
    if (rx_pop) begin
      state_nxt.rx_rd = state_r.rx_rd + 1'b1;
    end
    state_nxt.rx_lvl = state_r.rx_lvl + LVL_W'(rx_push) - LVL_W'(rx_pop);
    if (tx_push) begin
      state_nxt.tx_mem[state_r.tx_wr] = tx_word;
      state_nxt.tx_wr = state_r.tx_wr + 1'b1;
    end
    if (tx_pop) begin
      state_nxt.tx_rd = state_r.tx_rd + 1'b1;
    end
    state_nxt.tx_lvl = state_r.tx_lvl + LVL_W'(tx_push) - LVL_W'(tx_pop);

    // ----------------------------------------------------------------
    // DMA pacing from the new levels, so the lines match them except during reset and the first cycle after it
    // ----------------------------------------------------------------
    state_nxt.dma.tx_panic = state_nxt.tx_lvl < state_nxt.thr[THR_TXP_LO +: 7];
    state_nxt.dma.rx_panic = state_nxt.rx_lvl > state_nxt.thr[THR_RXP_LO +: 7];
    state_nxt.dma.tx_dma_request_line  = state_nxt.tx_lvl < state_nxt.thr[THR_TXR_LO +: 7];
    state_nxt.dma.rx_dma_request_line  = state_nxt.rx_lvl > state_nxt.thr[THR_RXR_LO +: 7];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset; thresholds come up at their documented levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= '0;
      state_r.thr <= THR_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign s_axi_awready    = state_r.awready;
  assign s_axi_wready     = state_r.wready;
  assign s_axi_bvalid     = state_r.bvalid;
  assign s_axi_bresp      = state_r.bresp;
  assign s_axi_arready    = state_r.arready;
  assign s_axi_rvalid     = state_r.rvalid;
  assign s_axi_rresp      = state_r.rresp;
  assign s_axi_rdata      = state_r.rdata;
  assign pcm_data_out     = state_r.dout;
  assign dma_request_line = state_r.dma;
endmodule : pcmsl_top
`default_nettype wire

// file: pcmsl_top_tb.sv
// Purpose: Register, pacing and slot tests of pcmsl_top
// Assumes: Slots 25 bits at 6 and 8 bits at 36 (wrapping), then packed, then one off
// Notes:   Expected FIFO reads come from the frame patterns, sent bits from W0 to W2
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module pcmsl_top_tb;
  import pcmsl_pkg::*;
  // Bench signals
  logic        aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        pcm_bit_clk, pcm_frame_sync, pcm_data_in, pcm_data_out;
  logic [39:0] cap1, cap2;
  pcmsl_dma_t  dma_request_line;
  int          fail_count = 0;
  int          n_tests = 0;
  localparam logic [39:0] P1 = 40'h96_c3a5_5a3c, P2 = 40'h5a_0ff0_3cc3;
  localparam logic [31:0] W0 = 32'h0155_aa33, W1 = 32'h0000_00b7, W2 = 32'h01c3_3c5a;
  pcmsl_top u_pcmsl_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pcm_bit_clk, .pcm_frame_sync, .pcm_data_in, .pcm_data_out,
    .dma_request_line);
  pcmsl_codec u_pcmsl_codec (.bclk(pcm_bit_clk), .fs(pcm_frame_sync), .din(pcm_data_in),
    .dout(pcm_data_out));
  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Bus write, each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // Bus read, data taken at the answer edge
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    `CHK(rd, e)
  endtask : rchk
  // Pacing lines as {tx_dma_request_line, tx_panic, rx_dma_request_line, rx_panic}
  task automatic dchk(input logic [3:0] e);
    @(posedge aclk);
    `CHK(dma_request_line, e)
  endtask : dchk
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // Hang guard, a few times the expected run
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    dchk(4'h0);
    dchk(4'hc);
    rchk(OFS_THR, THR_RESET);
    rchk(OFS_RX_SLOT, 32'h0);
    rdr(8'h18);
    `CHK(rs, RESP_SLVERR)
    wr(8'h18, 32'h0);
    `CHK(rs, RESP_SLVERR)
    $display("test reset done");
    wr(OFS_THR, 32'hffff_ffff);
    rchk(OFS_THR, THR_MASK);
    wr(OFS_THR, 32'h0101_0200);
    wr(OFS_RX_SLOT, 32'h4240_c061);
    wr(OFS_TX_SLOT, 32'h4240_c061);
    wr(OFS_FIFO, W0);
    dchk(4'h8);
    wr(OFS_FIFO, W1);
    dchk(4'h0);
    wr(OFS_FIFO, W2);
    $display("test pacing done");
    wr(OFS_CTRL, 32'h1);
    u_pcmsl_codec.frame(P1, cap1);
    u_pcmsl_codec.frame(P2, cap2);
    wr(OFS_CTRL, 32'h0);
    dchk(4'hf);
    `CHK(cap1[39:34], 6'h0)
    `CHK(cap1[33:9], W0[24:0])
    `CHK({cap1[3:0], cap2[39:36]}, W1[7:0])
    `CHK(cap2[33:9], W2[24:0])
    rchk(OFS_FIFO, {7'h0, P1[33:9]});
    rchk(OFS_FIFO, {24'h0, P1[3:0], P2[39:36]});
    rchk(OFS_FIFO, {7'h0, P2[33:9]});
    dchk(4'hc);
    $display("test frames done");
    wr(OFS_FIFO, W2);
    wr(OFS_CTRL, 32'h7);
    u_pcmsl_codec.frame(P1, cap1);
    u_pcmsl_codec.frame(P2, cap2);
    wr(OFS_CTRL, 32'h0);
    `CHK(cap1[33:18], W2[15:0])
    `CHK(cap1[17:4], 14'h0)
    `CHK({cap1[3:0], cap2[39:36]}, W2[23:16])
    rchk(OFS_FIFO, {8'h0, P1[3:0], P2[39:36], P1[33:18]});
    $display("test packing done");
    wr(OFS_RX_SLOT, 32'h4240_8061);
    wr(OFS_TX_SLOT, 32'h4240_8061);
    wr(OFS_FIFO, 32'h0000_00a5);
    wr(OFS_CTRL, 32'h1);
    u_pcmsl_codec.frame(P1, cap1);
    wr(OFS_CTRL, 32'h0);
    `CHK(cap1[33:9], 25'h0)
    `CHK(cap1[3:0], 4'ha)
    rchk(OFS_STAT, 32'h0);
    $display("test disabled slot done");
    conclude();
  end
endmodule : pcmsl_top_tb
`default_nettype wire
